/* include/adc_cfg_defines.svh */
// constants for the converter gain and chop/detect configuration bank
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH

// printed register indices; byte address is four times the index
`define IDX_GAIN_LO        4'h4
`define IDX_GAIN_HI        4'h5
`define IDX_CFG            4'h6
`define IDX_TO_BYTE_SHIFT  2

// bus widths
`define ADDR_W             8
`define DATA_W             32
`define STRB_W             4
`define REG_W              16

// reset values
`define RST_GAIN           16'h0000
`define RST_CFG            16'h0600

// decoded quantities at reset: gain 1, chop wait 16, one threshold, length 128
`define RST_GAIN_FACTOR    8'h01
`define RST_CHOP_WAIT      17'h0_0010
`define RST_THRESH_HITS    8'h01
`define RST_MEAS_LEN       12'h080

// shortest chop wait, reached at code zero
`define CHOP_WAIT_MIN      17'h0_0002

// current-detect measurement length per code, in conversion periods
`define MEAS_LEN_0         12'h080
`define MEAS_LEN_1         12'h100
`define MEAS_LEN_2         12'h200
`define MEAS_LEN_3         12'h300
`define MEAS_LEN_4         12'h500
`define MEAS_LEN_5         12'h700
`define MEAS_LEN_6         12'ha00
`define MEAS_LEN_7         12'he00

// writable bits; everything else is reserved and held at zero
`define GAIN_WMASK         16'h7777
`define CFG_WMASK          16'h1fff

// field geometry
`define AMP_LVL_W          3
`define CHANNELS           8
`define CH_PER_GROUP       4

// bus responses
`define RESP_OKAY          2'b00
`define RESP_DECERR        2'b11

`endif

/* include/adc_cfg_pkg.sv */
// types shared by the gain and configuration bank and its decoder
package adc_cfg_pkg;

  // one channel slot: reserved bit above a 3-bit gain selector
  typedef struct packed {
    logic       rsvd;
    logic [2:0] level;
  } amp_slot_t;

  // four channel slots; slot 0 sits in bits 3:0
  typedef amp_slot_t [3:0] gain_group_t;

  // chop and current-detect configuration word
  typedef struct packed {
    logic [2:0] rsvd;
    logic [3:0] chop_settle_delay;
    logic       chop_enable;
    logic       detect_all_channels;
    logic [2:0] detect_threshold_count;
    logic [2:0] detect_measure_length;
    logic       current_detect_enable;
  } cfg_reg_t;

  // decoded quantities for the analog and detect logic
  typedef struct packed {
    logic [7:0][7:0] gain_factor;
    logic [16:0]     chop_wait_cycles;
    logic [7:0]      detect_threshold_hits;
    logic [11:0]     detect_length_periods;
  } decoded_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;

  // whole state of the register bank
  typedef struct packed {
    wr_state_t   wst;
    rd_state_t   rst;
    logic        awready;
    logic        wready;
    logic        arready;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_held;
    logic [7:0]  awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    gain_group_t gain_lo;
    gain_group_t gain_hi;
    cfg_reg_t    cfg;
    decoded_t    dec;
  } bank_state_t;

endpackage

/* logic/adc_cfg_decode.sv */
// decodes gain, chop delay and current-detect codes into plain quantities
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"

module adc_cfg_decode
  import adc_cfg_pkg::*;
(
  input  wire gain_group_t gain_lo_in,
  input  wire gain_group_t gain_hi_in,
  input  wire cfg_reg_t    cfg_in,
  output decoded_t         decoded_out
);

  // two raised to a 3-bit code, 1 to 128
  function automatic logic [7:0] pow2_code(input logic [2:0] code);
    pow2_code = 8'h01 << code;
  endfunction

  // measurement length in conversion periods
  function automatic logic [11:0] measure_len(input logic [2:0] code);
    case (code)
      3'h0:    measure_len = `MEAS_LEN_0;
      3'h1:    measure_len = `MEAS_LEN_1;
      3'h2:    measure_len = `MEAS_LEN_2;
      3'h3:    measure_len = `MEAS_LEN_3;
      3'h4:    measure_len = `MEAS_LEN_4;
      3'h5:    measure_len = `MEAS_LEN_5;
      3'h6:    measure_len = `MEAS_LEN_6;
      default: measure_len = `MEAS_LEN_7;
    endcase
  endfunction

  // per-channel gain, chop wait and detect settings
  always_comb begin
    for (int i = 0; i < `CH_PER_GROUP; i++) begin
      decoded_out.gain_factor[i]                 = pow2_code(gain_lo_in[i].level);
      decoded_out.gain_factor[i + `CH_PER_GROUP] = pow2_code(gain_hi_in[i].level);
    end
    decoded_out.chop_wait_cycles = `CHOP_WAIT_MIN << cfg_in.chop_settle_delay;
    decoded_out.detect_threshold_hits = pow2_code(cfg_in.detect_threshold_count);
    decoded_out.detect_length_periods = measure_len(cfg_in.detect_measure_length);
  end

endmodule // adc_cfg_decode

/* logic/adc_cfg_regs.sv */
// gain selector and chop/current-detect register bank behind an axi4-lite slave
//
// Overview of operation
// - The second gain register, channels four to seven, sits at index 5h and resets to zero.
// - Channels 0 to 3 occupy bits 2:0, 6:4, 10:8, 14:12 of the first, bits 3/7/11/15 reserved.
// - Channels 4 to 7 occupy bits 2:0, 6:4, 10:8, 14:12 of the second, same reserved bits.
// - A gain selector picks a gain of two to the code, 1 at 000b up to 128 at 111b.
// - The configuration register sits at index 06h, resets to 0600h, with the usual fields.
// - The chop delay code waits two to the code plus one modulator periods, 2 to 65536.
// - The threshold count code asks for two to the code exceeded thresholds, 1 to 128.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"

module adc_cfg_regs
  import adc_cfg_pkg::*;
(
  input  wire logic                   mclk_in,
  input  wire logic                   reset_n_in,
  // write address channel
  input  wire logic                   s_awvalid_in,
  output logic                        s_awready_out,
  input  wire logic [`ADDR_W-1:0]     s_awaddr_in,
  // write data channel
  input  wire logic                   s_wvalid_in,
  output logic                        s_wready_out,
  input  wire logic [`DATA_W-1:0]     s_wdata_in,
  input  wire logic [`STRB_W-1:0]     s_wstrb_in,
  // write response channel
  output logic                        s_bvalid_out,
  input  wire logic                   s_bready_in,
  output logic [1:0]                  s_bresp_out,
  // read address channel
  input  wire logic                   s_arvalid_in,
  output logic                        s_arready_out,
  input  wire logic [`ADDR_W-1:0]     s_araddr_in,
  // read data channel
  output logic                        s_rvalid_out,
  input  wire logic                   s_rready_in,
  output logic [`DATA_W-1:0]          s_rdata_out,
  output logic [1:0]                  s_rresp_out,
  // raw fields towards the analog front end
  output logic [`CHANNELS-1:0][2:0]   amp_level_out,
  output cfg_reg_t                    cfg_out,
  // decoded quantities, one cycle behind the register fields
  output decoded_t                    decoded_out
);

  bank_state_t st_ff;
  bank_state_t nxt_st;
  decoded_t    dec_comb;

  // byte address of a printed register index
  function automatic logic [`ADDR_W-1:0] byte_addr(input logic [3:0] idx);
    byte_addr = {{(`ADDR_W-4){1'b0}}, idx} << `IDX_TO_BYTE_SHIFT;
  endfunction

  // merge a write into a 16-bit register by byte lane, reserved bits forced low
  function automatic logic [`REG_W-1:0] merge(
    input logic [`REG_W-1:0]  old_val,
    input logic [`DATA_W-1:0] data,
    input logic [`STRB_W-1:0] strb,
    input logic [`REG_W-1:0]  wmask
  );
    logic [`REG_W-1:0] val;
    val = old_val;
    if (strb[0]) begin
      val[7:0] = data[7:0];
    end
    if (strb[1]) begin
      val[15:8] = data[15:8];
    end
    merge = val & wmask;
  endfunction

  // known register address test
  function automatic logic addr_hit(input logic [`ADDR_W-1:0] addr);
    addr_hit = (addr == byte_addr(`IDX_GAIN_LO)) ||
               (addr == byte_addr(`IDX_GAIN_HI)) ||
               (addr == byte_addr(`IDX_CFG));
  endfunction

  // code to quantity decoding
  adc_cfg_decode u_decode (
    .gain_lo_in  (st_ff.gain_lo),
    .gain_hi_in  (st_ff.gain_hi),
    .cfg_in      (st_ff.cfg),
    .decoded_out (dec_comb)
  );

  // next-state logic of both bus halves and the registers
  always_comb begin
    logic [`ADDR_W-1:0] waddr;
    logic [`DATA_W-1:0] wdata;
    logic [`STRB_W-1:0] wstrb;
    logic [`REG_W-1:0]  rval;
    waddr  = '0;
    wdata  = '0;
    wstrb  = '0;
    rval   = '0;
    nxt_st = st_ff;

    // latch decoded quantities every cycle
    nxt_st.dec = dec_comb;

    // write address and data are taken independently, in either order
    if (s_awvalid_in && st_ff.awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr  = s_awaddr_in;
    end
    if (s_wvalid_in && st_ff.wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata  = s_wdata_in;
      nxt_st.wstrb  = s_wstrb_in;
    end

    // write state machine
    case (st_ff.wst)
      WR_IDLE: begin
        if (nxt_st.aw_held && nxt_st.w_held) begin
          waddr = nxt_st.awaddr;
          wdata = nxt_st.wdata;
          wstrb = nxt_st.wstrb;
          nxt_st.bresp = `RESP_OKAY;
          // address decode of the write
          if (waddr == byte_addr(`IDX_GAIN_LO)) begin
            nxt_st.gain_lo = merge(st_ff.gain_lo, wdata, wstrb, `GAIN_WMASK);
          end else if (waddr == byte_addr(`IDX_GAIN_HI)) begin
            nxt_st.gain_hi = merge(st_ff.gain_hi, wdata, wstrb, `GAIN_WMASK);
          end else if (waddr == byte_addr(`IDX_CFG)) begin
            nxt_st.cfg = merge(st_ff.cfg, wdata, wstrb, `CFG_WMASK);
          end else begin
            nxt_st.bresp = `RESP_DECERR; // unmapped write is dropped
          end
          nxt_st.aw_held = 1'b0;
          nxt_st.w_held  = 1'b0;
          nxt_st.wst     = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_bready_in) begin
          nxt_st.wst = WR_IDLE;
        end
      end
      default: begin
        nxt_st.wst = WR_IDLE;
      end
    endcase

    // each channel is ready while it holds nothing itself and no response pends
    nxt_st.awready = !nxt_st.aw_held && (nxt_st.wst == WR_IDLE);
    nxt_st.wready  = !nxt_st.w_held && (nxt_st.wst == WR_IDLE);

    // read state machine
    case (st_ff.rst)
      RD_IDLE: begin
        if (s_arvalid_in && st_ff.arready) begin
          nxt_st.rresp = `RESP_OKAY;
          // address decode of the read; reserved bits are never stored
          if (s_araddr_in == byte_addr(`IDX_GAIN_LO)) begin
            rval = st_ff.gain_lo & `GAIN_WMASK;
          end else if (s_araddr_in == byte_addr(`IDX_GAIN_HI)) begin
            rval = st_ff.gain_hi & `GAIN_WMASK;
          end else if (s_araddr_in == byte_addr(`IDX_CFG)) begin
            rval = st_ff.cfg & `CFG_WMASK;
          end else begin
            nxt_st.rresp = `RESP_DECERR;
          end
          nxt_st.rdata   = {{(`DATA_W-`REG_W){1'b0}}, rval};
          nxt_st.arready = 1'b0;
          nxt_st.rst     = RD_DATA;
        end
      end
      RD_DATA: begin
        if (s_rready_in) begin
          nxt_st.arready = 1'b1;
          nxt_st.rst     = RD_IDLE;
        end
      end
      default: begin
        nxt_st.rst = RD_IDLE;
      end
    endcase
  end

  // state register with documented reset values
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff.wst     <= WR_IDLE;
      st_ff.rst     <= RD_IDLE;
      st_ff.awready <= 1'b1;
      st_ff.wready  <= 1'b1;
      st_ff.arready <= 1'b1;
      st_ff.bresp   <= `RESP_OKAY;
      st_ff.rresp   <= `RESP_OKAY;
      st_ff.rdata   <= 32'h0000_0000;
      st_ff.aw_held <= 1'b0;
      st_ff.awaddr  <= 8'h00;
      st_ff.w_held  <= 1'b0;
      st_ff.wdata   <= 32'h0000_0000;
      st_ff.wstrb   <= 4'h0;
      st_ff.gain_lo <= `RST_GAIN;
      st_ff.gain_hi <= `RST_GAIN;
      st_ff.cfg     <= `RST_CFG;
      // decoded defaults: gain 1, chop wait 16, one threshold, length 128
      st_ff.dec.gain_factor           <= {`CHANNELS{`RST_GAIN_FACTOR}};
      st_ff.dec.chop_wait_cycles      <= `RST_CHOP_WAIT;
      st_ff.dec.detect_threshold_hits <= `RST_THRESH_HITS;
      st_ff.dec.detect_length_periods <= `RST_MEAS_LEN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // bus outputs straight from the state register
  assign s_awready_out = st_ff.awready;
  assign s_wready_out  = st_ff.wready;
  assign s_bvalid_out  = st_ff.wst[1];
  assign s_bresp_out   = st_ff.bresp;
  assign s_arready_out = st_ff.arready;
  assign s_rvalid_out  = st_ff.rst[1];
  assign s_rdata_out   = st_ff.rdata;
  assign s_rresp_out   = st_ff.rresp;

  // field outputs, channel 0 to 3 from the low group, 4 to 7 from the high
  always_comb begin
    for (int i = 0; i < `CH_PER_GROUP; i++) begin
      amp_level_out[i]                 = st_ff.gain_lo[i].level;
      amp_level_out[i + `CH_PER_GROUP] = st_ff.gain_hi[i].level;
    end
  end

  assign cfg_out     = st_ff.cfg;
  assign decoded_out = st_ff.dec;

endmodule // adc_cfg_regs

/* bench/adc_cfg_regs_properties.sv */
// assertion checker for the gain and configuration register bank
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_cfg_regs_properties
  import adc_cfg_pkg::*;
(
  input wire logic                 mclk_in,
  input wire logic                 reset_n_in,
  input wire logic                 s_awvalid_in,
  input wire logic                 s_awready_out,
  input wire logic [`ADDR_W-1:0]   s_awaddr_in,
  input wire logic                 s_wvalid_in,
  input wire logic                 s_wready_out,
  input wire logic [`DATA_W-1:0]   s_wdata_in,
  input wire logic [`STRB_W-1:0]   s_wstrb_in,
  input wire logic                 s_bvalid_out,
  input wire logic [1:0]           s_bresp_out,
  input wire logic                 s_arvalid_in,
  input wire logic                 s_arready_out,
  input wire logic                 s_rvalid_out,
  input wire logic [`DATA_W-1:0]   s_rdata_out,
  input wire logic [`CHANNELS-1:0][2:0] amp_level_out,
  input wire cfg_reg_t             cfg_out,
  input wire decoded_t             decoded_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // write of both low byte lanes with address and data taken at one edge
  logic wr_go;
  assign wr_go = s_awvalid_in && s_awready_out && s_wvalid_in && s_wready_out
                 && s_wstrb_in[1:0] == 2'b11;
  chk_gain_reset_zero: assert property ($rose(reset_n_in) |-> amp_level_out == '0)
    else $error("gain codes not zero after reset");
  chk_cfg_reset_val: assert property ($rose(reset_n_in) |-> cfg_out == 16'h0600)
    else $error("config word wrong after reset");
  chk_lo_lands: assert property (wr_go && s_awaddr_in == 8'h10 |=>
    amp_level_out[0] == $past(s_wdata_in[2:0]) && amp_level_out[3] == $past(s_wdata_in[14:12]))
    else $error("low gain group fields misplaced");
  chk_hi_lands: assert property (wr_go && s_awaddr_in == 8'h14 |=>
    amp_level_out[4] == $past(s_wdata_in[2:0]) && amp_level_out[6] == $past(s_wdata_in[10:8]))
    else $error("high gain group fields misplaced");
  chk_cfg_lands: assert property (wr_go && s_awaddr_in == 8'h18 |=>
    cfg_out == ($past(s_wdata_in[15:0]) & 16'h1fff))
    else $error("config word not written as expected");
  chk_gain_pow: assert property (1'b1 |=>
    decoded_out.gain_factor[7] == (8'h01 << $past(amp_level_out[7])))
    else $error("gain factor not two to the code");
  chk_chop_pow: assert property (1'b1 |=>
    decoded_out.chop_wait_cycles == (17'h0_0001 << ($past(cfg_out.chop_settle_delay) + 1)))
    else $error("chop wait not two to code plus one");
  chk_thresh_pow: assert property (1'b1 |=>
    decoded_out.detect_threshold_hits == (8'h01 << $past(cfg_out.detect_threshold_count)))
    else $error("threshold hits not two to the code");
  chk_rsvd_read: assert property (s_rvalid_out |-> s_rdata_out[31:15] == '0)
    else $error("reserved read bits not zero");
  chk_read_answer: assert property (s_arvalid_in && s_arready_out |=> s_rvalid_out)
    else $error("read answer late");
  // main traffic seen
  cov_write: cover property (wr_go);
  cov_read: cover property (s_arvalid_in && s_arready_out);
  cov_decerr: cover property (s_bvalid_out && s_bresp_out == 2'b11);
endmodule // adc_cfg_regs_properties

bind adc_cfg_regs adc_cfg_regs_properties u_adc_cfg_regs_properties (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .s_awvalid_in(s_awvalid_in),
  .s_awready_out(s_awready_out), .s_awaddr_in(s_awaddr_in), .s_wvalid_in(s_wvalid_in),
  .s_wready_out(s_wready_out), .s_wdata_in(s_wdata_in), .s_wstrb_in(s_wstrb_in),
  .s_bvalid_out(s_bvalid_out), .s_bresp_out(s_bresp_out), .s_arvalid_in(s_arvalid_in),
  .s_arready_out(s_arready_out), .s_rvalid_out(s_rvalid_out), .s_rdata_out(s_rdata_out),
  .amp_level_out(amp_level_out), .cfg_out(cfg_out), .decoded_out(decoded_out));

/* bench/adc_cfg_regs_test.sv */
// self-checking testbench for the gain and configuration register bank
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"
module adc_cfg_regs_test;
  import adc_cfg_pkg::*;
  logic mclk_in = 0, reset_n_in = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0][2:0] amp;
  cfg_reg_t cfg;
  decoded_t dec;
  int errors = 0;
  int check_count = 0;

  adc_cfg_regs u_adc_cfg_regs (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .s_awvalid_in(awvalid), .s_awready_out(awready), .s_awaddr_in(awaddr),
    .s_wvalid_in(wvalid), .s_wready_out(wready), .s_wdata_in(wdata), .s_wstrb_in(wstrb),
    .s_bvalid_out(bvalid), .s_bready_in(bready), .s_bresp_out(bresp),
    .s_arvalid_in(arvalid), .s_arready_out(arready), .s_araddr_in(araddr),
    .s_rvalid_out(rvalid), .s_rready_in(rready), .s_rdata_out(rdata), .s_rresp_out(rresp),
    .amp_level_out(amp), .cfg_out(cfg), .decoded_out(dec));

  // 125 MHz clock
  always #4 mclk_in = ~mclk_in;

  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // reset held low for 16 cycles
  task do_reset;
    @(posedge mclk_in);
    reset_n_in <= 0;
    repeat (16) @(posedge mclk_in);
    reset_n_in <= 1;
  endtask

  // one write; each channel released at its own handshake edge
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
          output logic [1:0] r);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge mclk_in);
    awvalid <= 1;
    awaddr  <= a;
    wvalid  <= 1;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1;
    while (!(ad && dd)) begin
      @(posedge mclk_in);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 0;
      end
      if (!dd && wready) begin
        dd = 1;
        wvalid <= 0;
      end
    end
    while (!bvalid) @(posedge mclk_in);
    r = bresp;
    bready <= 0;
  endtask

  // one read; rready held until rvalid is sampled
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    arvalid <= 1;
    araddr  <= a;
    rready  <= 1;
    do @(posedge mclk_in); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge mclk_in);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  task t_defaults;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h10, d, r);
    check(d, 32'h0000_0000);
    check(r, 32'h0000_0000);
    rd(8'h14, d, r);
    check(d, 32'h0000_0000);
    check(r, 32'h0000_0000);
    rd(8'h18, d, r);
    check(d, 32'h0000_0600);
    check(r, 32'h0000_0000);
    check(cfg, 32'h0000_0600);
    check(amp, 32'h0000_0000);
    check(dec.chop_wait_cycles, 32'h0000_0010);
    check(dec.detect_threshold_hits, 32'h0000_0001);
    check(dec.detect_length_periods, 32'h0000_0080);
    for (int i = 0; i < 8; i++) begin
      check(dec.gain_factor[i], 32'h0000_0001);
    end
  endtask

  task t_gain;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h10, 32'hffff_ffff, 4'h3, r);
    check(r, 32'h0000_0000);
    rd(8'h10, d, r);
    check(d, 32'h0000_7777);
    wr(8'h10, 32'h0000_3210, 4'h3, r);
    wr(8'h14, 32'h0000_7654, 4'h3, r);
    check(r, 32'h0000_0000);
    rd(8'h10, d, r);
    check(d, 32'h0000_3210);
    rd(8'h14, d, r);
    check(d, 32'h0000_7654);
    for (int i = 0; i < 8; i++) begin
      check(amp[i], i);
      check(dec.gain_factor[i], 1 << i);
    end
    // low byte lane only: channels 6 and 7 keep their codes
    wr(8'h14, 32'hffff_0000, 4'h1, r);
    rd(8'h14, d, r);
    check(d, 32'h0000_7600);
  endtask

  task t_cfg;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h18, 32'hffff_ffff, 4'h3, r);
    rd(8'h18, d, r);
    check(d, 32'h0000_1fff);
    check(cfg, 32'h0000_1fff);
    check(dec.chop_wait_cycles, 32'h0001_0000);
    check(dec.detect_threshold_hits, 32'h0000_0080);
    check(dec.detect_length_periods, 32'h0000_0e00);
    wr(8'h18, 32'h0000_0000, 4'h3, r);
    rd(8'h18, d, r);
    check(d, 32'h0000_0000);
    check(dec.chop_wait_cycles, 32'h0000_0002);
    check(dec.detect_threshold_hits, 32'h0000_0001);
    wr(8'h18, 32'h0000_1234, 4'h3, r);
    rd(8'h18, d, r);
    check(cfg.chop_settle_delay, 32'h0000_0009);
    check(cfg.detect_threshold_count, 32'h0000_0003);
    check(cfg.detect_measure_length, 32'h0000_0002);
    check(dec.chop_wait_cycles, 32'h0000_0400);
    check(dec.detect_threshold_hits, 32'h0000_0008);
    check(dec.detect_length_periods, 32'h0000_0200);
  endtask

  // unmapped and misaligned places answer with an error and change nothing
  task t_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h1c, 32'hffff_ffff, 4'h3, r);
    check(r, 32'h0000_0003);
    rd(8'h0c, d, r);
    check(r, 32'h0000_0003);
    check(d, 32'h0000_0000);
    rd(8'h11, d, r);
    check(r, 32'h0000_0003);
    rd(8'h10, d, r);
    check(d, 32'h0000_3210);
    rd(8'h18, d, r);
    check(d, 32'h0000_1234);
  endtask

  initial begin
    do_reset;
    t_defaults;
    t_gain;
    t_cfg;
    t_unmapped;
    do_reset;
    t_defaults;
    end_sim;
  end

  // watchdog for a hung handshake
  initial begin
    #200000;
    errors++;
    end_sim;
  end
endmodule // adc_cfg_regs_test
